//--- include/scc_pkg.sv
// constants for the conversion-start control block
package scc_pkg;
	localparam int unsigned CLK_FREQ_HZ       = 50_000_000;
	// acquisition phase length in ns
	localparam int unsigned ACQ_TIME_NS       = 1000;
	// conversion phase length in ns
	localparam int unsigned CONV_TIME_NS      = 1000;
	localparam int unsigned CLK_PERIOD_NS     = 1_000_000_000 / CLK_FREQ_HZ;
	// least times, rounded up to whole cycles
	localparam int unsigned ACQ_CYCLES        = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CONV_CYCLES       = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W             = 8;
	localparam logic [7:0]  CNT_ZERO          = 8'h00;
	localparam logic [7:0]  ACQ_LOAD          = 8'(ACQ_CYCLES - 1);
	localparam logic [7:0]  CONV_LOAD         = 8'(CONV_CYCLES - 1);
	localparam logic [15:0] DATA_RESET        = 16'h0000;

	typedef enum logic [4:0] {
		SCC_ACQ   = 5'h01,
		SCC_ARMED = 5'h02,
		SCC_CONV  = 5'h04,
		SCC_LATCH = 5'h08,
		SCC_PWDN  = 5'h10
	} scc_state_t;
endpackage

//--- rtl/scc_clk_gate.sv
// chip-select gating of the external serial clock
`timescale 1ns/1ps
module scc_clk_gate (
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic chip_select_n,
	input  wire logic ext_sclk,
	output logic      sclk_edge
);
	logic sclk_prev_q;
	logic sclk_prev_d;
	logic sclk_edge_q;
	logic sclk_edge_d;

	always_comb begin
		sclk_prev_d = ext_sclk;
		// edges count only while selected
		sclk_edge_d = ext_sclk & ~sclk_prev_q & ~chip_select_n;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sclk_prev_q <= 1'b0;
			sclk_edge_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_prev_d;
			sclk_edge_q <= sclk_edge_d;
		end
	end

	assign sclk_edge = sclk_edge_q;

	gate_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$past(chip_select_n) |-> !sclk_edge) else $error("clock edge passed while deselected");
endmodule // scc_clk_gate

//--- rtl/scc_conv_ctrl.sv
// conversion-start, power-down and reference select control
`timescale 1ns/1ps
module scc_conv_ctrl (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        reset_in,
	input  wire logic        power_down_in,
	input  wire logic        convert_start_n,
	input  wire logic        internal_ref_off,
	input  wire logic        ref_buffer_off,
	input  wire logic        chip_select_n,
	input  wire logic        ext_sclk,
	input  wire logic [15:0] conv_result,
	output logic             busy,
	output logic             sample_hold,
	output logic             low_power,
	output logic             int_ref_en,
	output logic             ref_buf_en,
	output logic [15:0]      shift_data,
	output logic             shift_clk_edge
);
	scc_pkg::scc_state_t state_q;
	scc_pkg::scc_state_t state_d;
	logic [7:0]          cnt_q;
	logic [7:0]          cnt_d;
	logic                start_prev_q;
	logic                start_prev_d;
	logic                busy_q;
	logic                busy_d;
	logic                hold_q;
	logic                hold_d;
	logic                lowp_q;
	logic                lowp_d;
	logic                iref_q;
	logic                iref_d;
	logic                rbuf_q;
	logic                rbuf_d;
	logic [15:0]         data_q;
	logic [15:0]         data_d;
	logic                start_fall;
	logic [7:0]          busy_run_q;
	logic [7:0]          busy_run_d;

	assign start_fall = start_prev_q & ~convert_start_n;

	always_comb begin
		state_d      = state_q;
		cnt_d        = cnt_q;
		start_prev_d = convert_start_n;
		busy_d       = busy_q;
		hold_d       = hold_q;
		lowp_d       = lowp_q;
		data_d       = data_q;
		iref_d       = ~internal_ref_off;
		rbuf_d       = ~ref_buffer_off;
		if (reset_in) begin
			// abort and restart acquisition
			state_d = scc_pkg::SCC_ACQ;
			cnt_d   = scc_pkg::ACQ_LOAD;
			busy_d  = 1'b0;
			hold_d  = 1'b0;
			lowp_d  = 1'b0;
		end else begin
			case (state_q)
				scc_pkg::SCC_ACQ: begin
					// starts here are ignored until acquisition ends
					if (cnt_q != scc_pkg::CNT_ZERO) begin
						cnt_d = cnt_q - 8'h01;
					end else if (power_down_in) begin
						state_d = scc_pkg::SCC_PWDN;
						lowp_d  = 1'b1;
					end else if (!convert_start_n) begin
						state_d = scc_pkg::SCC_CONV;
						cnt_d   = scc_pkg::CONV_LOAD;
						busy_d  = 1'b1;
						hold_d  = 1'b1;
					end else begin
						state_d = scc_pkg::SCC_ARMED;
					end
				end
				scc_pkg::SCC_ARMED: begin
					if (power_down_in) begin
						state_d = scc_pkg::SCC_PWDN;
						lowp_d  = 1'b1;
					end else if (start_fall) begin
						state_d = scc_pkg::SCC_CONV;
						cnt_d   = scc_pkg::CONV_LOAD;
						busy_d  = 1'b1;
						hold_d  = 1'b1;
					end
				end
				scc_pkg::SCC_CONV: begin
					// power-down does not cut a conversion short
					if (cnt_q != scc_pkg::CNT_ZERO) begin
						cnt_d = cnt_q - 8'h01;
					end else begin
						state_d = scc_pkg::SCC_LATCH;
						data_d  = conv_result;
					end
				end
				scc_pkg::SCC_LATCH: begin
					// busy falls once data sits in the shift register
					busy_d  = 1'b0;
					hold_d  = 1'b0;
					state_d = scc_pkg::SCC_ACQ;
					cnt_d   = scc_pkg::ACQ_LOAD;
				end
				scc_pkg::SCC_PWDN: begin
					if (!power_down_in) begin
						state_d = scc_pkg::SCC_ACQ;
						cnt_d   = scc_pkg::ACQ_LOAD;
						lowp_d  = 1'b0;
					end
				end
				default: begin
					state_d = scc_pkg::SCC_ACQ;
					cnt_d   = scc_pkg::ACQ_LOAD;
					busy_d  = 1'b0;
					hold_d  = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_q      <= scc_pkg::SCC_ACQ;
			cnt_q        <= scc_pkg::ACQ_LOAD;
			start_prev_q <= 1'b1;
			busy_q       <= 1'b0;
			hold_q       <= 1'b0;
			lowp_q       <= 1'b0;
			iref_q       <= 1'b1;
			rbuf_q       <= 1'b1;
			data_q       <= scc_pkg::DATA_RESET;
		end else begin
			state_q      <= state_d;
			cnt_q        <= cnt_d;
			start_prev_q <= start_prev_d;
			busy_q       <= busy_d;
			hold_q       <= hold_d;
			lowp_q       <= lowp_d;
			iref_q       <= iref_d;
			rbuf_q       <= rbuf_d;
			data_q       <= data_d;
		end
	end

	scc_clk_gate u_clk_gate (
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.chip_select_n (chip_select_n),
		.ext_sclk      (ext_sclk),
		.sclk_edge     (shift_clk_edge)
	);

	assign busy        = busy_q;
	assign sample_hold = hold_q;
	assign low_power   = lowp_q;
	assign int_ref_en  = iref_q;
	assign ref_buf_en  = rbuf_q;
	assign shift_data  = data_q;

	// cycles busy has stood, for the length check
	always_comb begin
		busy_run_d = busy_q ? (busy_run_q + 8'h01) : scc_pkg::CNT_ZERO;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			busy_run_q <= scc_pkg::CNT_ZERO;
		end else begin
			busy_run_q <= busy_run_d;
		end
	end

	busy_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		($fell(busy) && !$past(reset_in)) |-> busy_run_q == 8'(scc_pkg::CONV_CYCLES + 1))
		else $error("busy length wrong");

	sequence conv_run_s;
		busy ##1 busy [*3];
	endsequence

	reset_abort_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reset_in |=> !busy && !sample_hold) else $error("reset did not abort conversion");
	pd_finish_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == scc_pkg::SCC_CONV && !reset_in) |=> (busy || state_q == scc_pkg::SCC_LATCH))
		else $error("conversion cut short");
	pd_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		low_power |-> !busy) else $error("conversion in power-down");
	armed_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == scc_pkg::SCC_ARMED && start_fall && !reset_in && !power_down_in)
		|=> busy && sample_hold) else $error("falling edge did not start conversion");
	armed_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == scc_pkg::SCC_ARMED && !start_fall) |=> !busy) else $error("started without edge");
	low_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == scc_pkg::SCC_ACQ && cnt_q == scc_pkg::CNT_ZERO && !convert_start_n
		&& !power_down_in && !reset_in) |=> busy) else $error("low start not immediate");
	ref_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> int_ref_en == !$past(internal_ref_off)) else $error("reference select wrong");
	buf_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> ref_buf_en == !$past(ref_buffer_off)) else $error("buffer select wrong");
	busy_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		($rose(busy) && !reset_in) |-> conv_run_s) else $error("busy too short");
	busy_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == scc_pkg::SCC_LATCH && !reset_in) |=> !busy && shift_data == $past(data_q))
		else $error("busy did not fall at latch");
	acq_ignore_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(state_q == scc_pkg::SCC_ACQ && cnt_q != scc_pkg::CNT_ZERO) |=> !busy)
		else $error("start taken during acquisition");
endmodule // scc_conv_ctrl

//--- testbench/scc_host_model.sv
// host model driving conversion start, chip select and serial clock
`timescale 1ns/1ps
module scc_host_model (
	input  wire logic sys_clk,
	input  wire logic start_low,
	input  wire logic frame,
	input  wire logic rogue,
	output logic      convert_start_n = 1'b1,
	output logic      chip_select_n   = 1'b1,
	output logic      ext_sclk        = 1'b0
);
	logic div_q = 1'b0;
	// rogue runs the clock with chip select high on purpose
	always_ff @(posedge sys_clk) begin
		convert_start_n <= !start_low;
		chip_select_n   <= !frame;
		div_q           <= (frame || rogue) ? !div_q : 1'b0;
		ext_sclk        <= (frame || rogue) ? (ext_sclk ^ div_q) : 1'b0;
	end
endmodule // scc_host_model

//--- testbench/tb_top.sv
// self-checking bench for the conversion-start control
`timescale 1ns/1ps
module tb_top;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        reset_in = 1'b0;
	logic        power_down_in = 1'b0;
	logic        internal_ref_off = 1'b0;
	logic        ref_buffer_off = 1'b0;
	logic [15:0] conv_result = 16'hA5C3;
	logic        start_low = 1'b0;
	logic        frame = 1'b0;
	logic        rogue = 1'b0;
	logic        convert_start_n, chip_select_n, ext_sclk;
	logic        busy, sample_hold, low_power, int_ref_en, ref_buf_en, shift_clk_edge;
	logic [15:0] shift_data;
	int          err_count = 0;
	int          samples_checked = 0;
	int          n;

	initial forever #10 sys_clk = ~sys_clk;

	scc_host_model i_host (.sys_clk, .start_low, .frame, .rogue,
		.convert_start_n, .chip_select_n, .ext_sclk);

	scc_conv_ctrl i_dut (.sys_clk, .rst_n, .reset_in, .power_down_in, .convert_start_n,
		.internal_ref_off, .ref_buffer_off, .chip_select_n, .ext_sclk, .conv_result,
		.busy, .sample_hold, .low_power, .int_ref_en, .ref_buf_en, .shift_data,
		.shift_clk_edge);

	task automatic conclude();
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cycles(input int k);
		repeat (k) @(negedge sys_clk);
	endtask

	// n returns the cycles spent waiting
	task automatic wait_busy(input logic lvl, input int bound);
		n = 0;
		while (busy !== lvl && n < bound) begin
			@(negedge sys_clk);
			n++;
		end
		if (busy !== lvl) begin
			err_count++;
			$display("ERROR t=%0t busy got=%h exp=%h", $time, busy, lvl);
			conclude();
		end
	endtask

	// counts serial clock pulses seen through the gate
	task automatic burst(input logic cs_ok);
		n = 0;
		frame = cs_ok;
		rogue = !cs_ok;
		for (int k = 0; k < 44; k++) begin
			@(negedge sys_clk);
			if (k == 39) begin
				frame = 1'b0;
				rogue = 1'b0;
			end
			n += int'(shift_clk_edge);
		end
	endtask

	initial begin
		cycles(12);
		rst_n = 1'b1;
		check(16'(busy), 16'h0000);
		check(16'(int_ref_en), 16'h0001);
		check(16'(ref_buf_en), 16'h0001);
		check(shift_data, 16'h0000);
		cycles(80);
		check(16'(busy), 16'h0000);
		start_low = 1'b1;
		wait_busy(1'b1, 4);
		check(16'(sample_hold), 16'h0001);
		wait_busy(1'b0, 80);
		check(16'(n), 16'(scc_pkg::CONV_CYCLES + 1));
		check(shift_data, 16'hA5C3);
		$display("test edge start done");
		wait_busy(1'b1, 80);
		check(16'(n >= scc_pkg::ACQ_CYCLES && n <= scc_pkg::ACQ_CYCLES + 2), 16'h0001);
		check(16'(sample_hold), 16'h0001);
		start_low = 1'b0;
		cycles(3);
		start_low = 1'b1;
		cycles(2);
		start_low = 1'b0;
		wait_busy(1'b0, 80);
		cycles(80);
		check(16'(busy), 16'h0000);
		$display("test level start done");
		start_low = 1'b1;
		wait_busy(1'b1, 4);
		cycles(5);
		reset_in = 1'b1;
		cycles(1);
		reset_in = 1'b0;
		cycles(1);
		check(16'(busy), 16'h0000);
		check(16'(sample_hold), 16'h0000);
		conv_result = 16'h5A3C;
		wait_busy(1'b1, 80);
		power_down_in = 1'b1;
		wait_busy(1'b0, 80);
		check(shift_data, 16'h5A3C);
		cycles(80);
		check(16'(busy), 16'h0000);
		check(16'(low_power), 16'h0001);
		power_down_in = 1'b0;
		start_low = 1'b0;
		$display("test abort and power-down done");
		for (int i = 0; i < 4; i++) begin
			internal_ref_off = i[0];
			ref_buffer_off = i[1];
			cycles(2);
			check(16'(int_ref_en), 16'(!i[0]));
			check(16'(ref_buf_en), 16'(!i[1]));
		end
		burst(1'b1);
		check(16'(n), 16'h000A);
		burst(1'b0);
		check(16'(n), 16'h0000);
		check(16'(low_power), 16'h0000);
		$display("test selects and clock gate done");
		power_down_in = 1'b1;
		cycles(3);
		check(16'(low_power), 16'h0001);
		start_low = 1'b1;
		cycles(4);
		check(16'(busy), 16'h0000);
		power_down_in = 1'b0;
		wait_busy(1'b1, 80);
		check(16'(n >= scc_pkg::ACQ_CYCLES && n <= scc_pkg::ACQ_CYCLES + 2), 16'h0001);
		start_low = 1'b0;
		wait_busy(1'b0, 80);
		$display("test power-down from armed done");
		conclude();
	end
endmodule // tb_top
